// >>> logic/prc_cfg_regs.sv
// config words 0x2c to 0x3b: identity, expansion rom base, cap pointer
//
// Contract
// RL1: identity word at 0x2c, product high, maker low, read-only there.
// RL2: straps taken at reset pick rom load or config-space write source.
// RL3: rom mode fetches identity bytes from rom addresses 0x54 to 0x57.
// RL4: other mode: host writes 0x40-0x43, value shows in read-only word.
// RL5: rom base bits 31:22 writable, placing window on 4 MB boundary.
// RL6: rom base bits 21:11 read zero and ignore writes.
// RL7: rom base bit 0 is writable decode enable, reset 0.
// RL8: claim rom accesses only with memory space and decode enable set.
// RL9: 64 KB image sits at the lowest addresses of the window.
// RL10: agp strap: cap pointer reads 0x44 in bits 7:0, upper zero.
// RL11: no agp strap: cap pointer reads all zero.
// RL12: word 0x38 to 0x3b reads zero and ignores writes.
// RL13: maker field written at 0x40 appears at read-only 0x2c.
// RL14: writes to read-only bits complete normally, reserved bits read zero.
`timescale 1ns/1ps
`default_nettype none
`include "prc_cfg.svh"

module prc_cfg_regs (
   input  wire logic          clock_in,
   input  wire logic          reset_n_in,
   // straps, levels from the neighbouring rom pin logic
   input  wire logic          strap_rom_id_in,
   input  wire logic          strap_agp_in,
   // configuration access from the host bridge decoder
   input  wire logic          cfg_req_in,
   input  wire logic          cfg_write_in,
   input  wire prc_pkg::prc_byte_t cfg_addr_in,
   input  wire logic [3:0]    cfg_be_in,
   input  wire prc_pkg::prc_word_t cfg_wdata_in,
   output prc_pkg::prc_word_t cfg_rdata_out,
   output logic               cfg_ack_out,
   // writes to the alias word at 0x40, from neighbouring logic
   input  wire logic          alias_wr_in,
   input  wire logic [3:0]    alias_be_in,
   input  wire prc_pkg::prc_word_t alias_data_in,
   // command register memory space enable
   input  wire logic          mem_space_en_in,
   // memory cycle address for rom window decode
   input  wire logic          mem_req_in,
   input  wire prc_pkg::prc_word_t mem_addr_in,
   output logic               rom_claim_out,
   output logic               rom_in_image_out,
   output logic [15:0]        rom_offset_out,
   // boot rom byte port for the identity fetch
   output logic               rom_rd_out,
   output prc_pkg::prc_byte_t rom_addr_out,
   input  wire logic          rom_ack_in,
   input  wire prc_pkg::prc_byte_t rom_data_in,
   // identity word valid
   output logic               id_ready_out
);
   import prc_pkg::*;

   // ------------------------------------------------------------------
   // strap capture
   // ------------------------------------------------------------------
   logic live_r;
   logic live_nxt;
   logic strap_rom_r;
   logic strap_rom_nxt;
   logic strap_agp_r;
   logic strap_agp_nxt;
   logic go_r;
   logic go_nxt;

   // ------------------------------------------------------------------
   // identity word and fetch hand-off
   // ------------------------------------------------------------------
   prc_word_t id_word_r;
   prc_word_t id_word_nxt;
   logic      loaded_r;
   logic      loaded_nxt;
   logic      ready_r;
   logic      ready_nxt;
   prc_word_t fetch_word;
   logic      fetch_done;

   // ------------------------------------------------------------------
   // expansion rom base
   // ------------------------------------------------------------------
   logic [9:0] rombase_r;
   logic [9:0] rombase_nxt;
   logic       romdec_r;
   logic       romdec_nxt;

   // ------------------------------------------------------------------
   // config answer and rom decode outputs
   // ------------------------------------------------------------------
   prc_word_t   rdata_r;
   prc_word_t   rdata_nxt;
   logic        ack_r;
   logic        ack_nxt;
   logic        claim_r;
   logic        claim_nxt;
   logic        image_r;
   logic        image_nxt;
   logic [15:0] offset_r;
   logic [15:0] offset_nxt;

   logic        take;
   prc_byte_t   word_addr;
   prc_word_t   read_mux;

   // ------------------------------------------------------------------
   // identity fetch sequencer
   // ------------------------------------------------------------------
   prc_rom_fetch u_fetch (
      .clock_in    (clock_in),
      .reset_n_in  (reset_n_in),
      .start_in    (go_r),
      .rom_ack_in  (rom_ack_in),
      .rom_data_in (rom_data_in),
      .rom_rd_out  (rom_rd_out),
      .rom_addr_out(rom_addr_out),
      .word_out    (fetch_word),
      .done_out    (fetch_done)
   );

   // ------------------------------------------------------------------
   // straps caught on the first edge after reset release
   // ------------------------------------------------------------------
   always_comb begin
      live_nxt      = live_r;
      strap_rom_nxt = strap_rom_r;
      strap_agp_nxt = strap_agp_r;
      go_nxt        = 1'b0;
      // RL2: latch source strap
      if (!live_r) begin
         live_nxt      = 1'b1;
         strap_rom_nxt = strap_rom_id_in;
         strap_agp_nxt = strap_agp_in;
         go_nxt        = strap_rom_id_in;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         live_r      <= 1'b0;
         strap_rom_r <= 1'b0;
         strap_agp_r <= 1'b0;
         go_r        <= 1'b0;
      end else begin
         live_r      <= live_nxt;
         strap_rom_r <= strap_rom_nxt;
         strap_agp_r <= strap_agp_nxt;
         go_r        <= go_nxt;
      end
   end

   // ------------------------------------------------------------------
   // identity word: rom load once, alias bytes afterwards
   // ------------------------------------------------------------------
   always_comb begin
      id_word_nxt = id_word_r;
      loaded_nxt  = loaded_r;
      ready_nxt   = ready_r;
      // RL3: load fetched word
      if (fetch_done && !loaded_r) begin
         id_word_nxt = fetch_word;
         loaded_nxt  = 1'b1;
      end
      // RL4: alias write reflected
      // RL13: maker field aliased
      if (alias_wr_in) begin
         for (int b = 0; b < 4; b++) begin
            if (alias_be_in[b]) begin
               id_word_nxt[b*8 +: 8] = alias_data_in[b*8 +: 8];
            end
         end
      end
      // RL2: source decides readiness
      if (live_r) begin
         ready_nxt = !strap_rom_r || fetch_done;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         id_word_r <= `PRC_ID_RESET;
         loaded_r  <= 1'b0;
         ready_r   <= 1'b0;
      end else begin
         id_word_r <= id_word_nxt;
         loaded_r  <= loaded_nxt;
         ready_r   <= ready_nxt;
      end
   end

   // ------------------------------------------------------------------
   // config access decode and read mux
   // ------------------------------------------------------------------
   assign take      = cfg_req_in && !ack_r && ready_r;
   assign word_addr = {cfg_addr_in[7:2], 2'b00};

   always_comb begin
      read_mux = `PRC_ZERO_WORD;
      case (word_addr)
         // RL1: identity word read-only
         `PRC_OFS_SUBSYS: begin
            read_mux = id_word_r;
         end
         // RL6: low base bits zero
         `PRC_OFS_ROMBASE: begin
            read_mux[`PRC_ROMBASE_MSB:`PRC_ROMBASE_LSB] = rombase_r;
            read_mux[`PRC_ROMDEC_BIT] = romdec_r;
         end
         // RL10: agp pointer value
         // RL11: zero without agp
         `PRC_OFS_CAPPTR: begin
            if (strap_agp_r) begin
               read_mux[`PRC_CAP_MSB:0] = `PRC_CAP_FIRST;
            end
         end
         // RL12: reserved word zero
         `PRC_OFS_RSVD: begin
            read_mux = `PRC_ZERO_WORD;
         end
         default: begin
            read_mux = `PRC_ZERO_WORD;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // expansion rom base writes and config answer
   // ------------------------------------------------------------------
   always_comb begin
      rombase_nxt = rombase_r;
      romdec_nxt  = romdec_r;
      rdata_nxt   = rdata_r;
      ack_nxt     = 1'b0;
      if (take) begin
         // RL14: every access completes
         ack_nxt   = 1'b1;
         rdata_nxt = cfg_write_in ? `PRC_ZERO_WORD : read_mux;
         if (cfg_write_in && word_addr == `PRC_OFS_ROMBASE) begin
            // RL5: upper base bits
            if (cfg_be_in[3]) begin
               rombase_nxt[9:2] = cfg_wdata_in[31:24];
            end
            if (cfg_be_in[2]) begin
               rombase_nxt[1:0] = cfg_wdata_in[23:22];
            end
            // RL7: decode enable bit
            if (cfg_be_in[0]) begin
               romdec_nxt = cfg_wdata_in[`PRC_ROMDEC_BIT];
            end
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         rombase_r <= `PRC_ROMBASE_RESET;
         romdec_r  <= `PRC_ROMDEC_RESET;
         rdata_r   <= `PRC_ZERO_WORD;
         ack_r     <= 1'b0;
      end else begin
         rombase_r <= rombase_nxt;
         romdec_r  <= romdec_nxt;
         rdata_r   <= rdata_nxt;
         ack_r     <= ack_nxt;
      end
   end

   // ------------------------------------------------------------------
   // rom window decode for memory cycles
   // ------------------------------------------------------------------
   always_comb begin
      claim_nxt  = 1'b0;
      image_nxt  = 1'b0;
      offset_nxt = 16'h0000;
      // RL8: both enables needed
      if (mem_req_in && mem_space_en_in && romdec_r &&
          mem_addr_in[`PRC_ROMBASE_MSB:`PRC_ROMBASE_LSB] == rombase_r) begin
         claim_nxt  = 1'b1;
         // RL9: image at window bottom
         image_nxt  = mem_addr_in[21:16] == 6'h00;
         offset_nxt = mem_addr_in[`PRC_IMAGE_MSB:0];
      end
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         claim_r  <= 1'b0;
         image_r  <= 1'b0;
         offset_r <= 16'h0000;
      end else begin
         claim_r  <= claim_nxt;
         image_r  <= image_nxt;
         offset_r <= offset_nxt;
      end
   end

   // ------------------------------------------------------------------
   // outputs, all from flip-flops
   // ------------------------------------------------------------------
   assign cfg_rdata_out    = rdata_r;
   assign cfg_ack_out      = ack_r;
   assign rom_claim_out    = claim_r;
   assign rom_in_image_out = image_r;
   assign rom_offset_out   = offset_r;
   assign id_ready_out     = ready_r;

endmodule
`default_nettype wire

// >>> logic/prc_cfg.svh
// offsets, field positions, reset values and counts for the config block
`ifndef PRC_CFG_SVH
`define PRC_CFG_SVH

// ---------------------------------------------------------------------
// configuration byte offsets of the words in this range
// ---------------------------------------------------------------------
`define PRC_OFS_SUBSYS      8'h2c
`define PRC_OFS_ROMBASE     8'h30
`define PRC_OFS_CAPPTR      8'h34
`define PRC_OFS_RSVD        8'h38

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define PRC_PROD_MSB        31
`define PRC_PROD_LSB        16
`define PRC_MAKER_MSB       15
`define PRC_MAKER_LSB       0
`define PRC_ROMBASE_MSB     31
`define PRC_ROMBASE_LSB     22
`define PRC_ROMDEC_BIT      0
`define PRC_IMAGE_MSB       15
`define PRC_CAP_MSB         7

// ---------------------------------------------------------------------
// reset values and fixed answers
// ---------------------------------------------------------------------
`define PRC_ID_RESET        32'h0000_0000
`define PRC_ROMBASE_RESET   10'h000
`define PRC_ROMDEC_RESET    1'b0
`define PRC_CAP_FIRST       8'h44
`define PRC_ZERO_WORD       32'h0000_0000

// ---------------------------------------------------------------------
// boot rom identity fetch
// ---------------------------------------------------------------------
`define PRC_ROM_ID_FIRST    8'h54
`define PRC_ROM_ID_LAST_IDX 2'h3

`endif

// >>> logic/prc_pkg.sv
// types shared by the config block files
package prc_pkg;

   // ------------------------------------------------------------------
   // fetch sequencer states, gray coded along the path
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      PRC_ST_IDLE = 2'h0,
      PRC_ST_REQ  = 2'h1,
      PRC_ST_WAIT = 2'h3,
      PRC_ST_DONE = 2'h2
   } prc_fetch_e;

   typedef logic [31:0] prc_word_t;
   typedef logic [7:0]  prc_byte_t;

endpackage

// >>> logic/prc_rom_fetch.sv
// sequencer that reads the four identity bytes from the boot rom
`timescale 1ns/1ps
`default_nettype none
`include "prc_cfg.svh"

module prc_rom_fetch (
   input  wire logic          clock_in,
   input  wire logic          reset_n_in,
   input  wire logic          start_in,
   input  wire logic          rom_ack_in,
   input  wire prc_pkg::prc_byte_t rom_data_in,
   output logic               rom_rd_out,
   output prc_pkg::prc_byte_t rom_addr_out,
   output prc_pkg::prc_word_t word_out,
   output logic               done_out
);
   import prc_pkg::*;

   prc_fetch_e st_r;
   prc_fetch_e st_nxt;
   logic [1:0] idx_r;
   logic [1:0] idx_nxt;
   prc_word_t  word_r;
   prc_word_t  word_nxt;
   logic       rd_r;
   logic       rd_nxt;
   prc_byte_t  addr_r;
   prc_byte_t  addr_nxt;
   logic       done_r;
   logic       done_nxt;

   // ------------------------------------------------------------------
   // next state: one byte per request, lowest address to lowest lane
   // ------------------------------------------------------------------
   always_comb begin
      st_nxt   = st_r;
      idx_nxt  = idx_r;
      word_nxt = word_r;
      rd_nxt   = rd_r;
      addr_nxt = addr_r;
      done_nxt = done_r;
      case (st_r)
         PRC_ST_IDLE: begin
            if (start_in) begin
               idx_nxt = 2'h0;
               st_nxt  = PRC_ST_REQ;
            end
         end
         // RL3: rom byte address
         PRC_ST_REQ: begin
            rd_nxt   = 1'b1;
            addr_nxt = `PRC_ROM_ID_FIRST + {6'h00, idx_r};
            st_nxt   = PRC_ST_WAIT;
         end
         // RL3: gather identity bytes
         PRC_ST_WAIT: begin
            if (rom_ack_in) begin
               rd_nxt = 1'b0;
               word_nxt[{idx_r, 3'b000} +: 8] = rom_data_in;
               if (idx_r == `PRC_ROM_ID_LAST_IDX) begin
                  done_nxt = 1'b1;
                  st_nxt   = PRC_ST_DONE;
               end else begin
                  idx_nxt = idx_r + 2'h1;
                  st_nxt  = PRC_ST_REQ;
               end
            end
         end
         PRC_ST_DONE: begin
            st_nxt = PRC_ST_DONE; // one fetch per reset
         end
         default: begin
            st_nxt = PRC_ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         st_r   <= PRC_ST_IDLE;
         idx_r  <= 2'h0;
         word_r <= `PRC_ID_RESET;
         rd_r   <= 1'b0;
         addr_r <= 8'h00;
         done_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         idx_r  <= idx_nxt;
         word_r <= word_nxt;
         rd_r   <= rd_nxt;
         addr_r <= addr_nxt;
         done_r <= done_nxt;
      end
   end

   assign rom_rd_out   = rd_r;
   assign rom_addr_out = addr_r;
   assign word_out     = word_r;
   assign done_out     = done_r;

endmodule
`default_nettype wire

// >>> bench/prc_rom_model.sv
// boot rom byte port model answering the identity fetch
`timescale 1ns/1ps
`default_nettype none

module prc_rom_model (
   input  wire logic               clock_in,
   input  wire logic [2:0]         wait_in,
   input  wire logic               rom_rd_in,
   input  wire prc_pkg::prc_byte_t rom_addr_in,
   output logic                    rom_ack_out,
   output prc_pkg::prc_byte_t      rom_data_out
);
   logic [2:0] cnt;

   initial begin
      rom_ack_out = 1'b0;
      rom_data_out = 8'h00;
      cnt = 3'h0;
   end

   // bytes at 0x54..0x57
   // answer after wait_in idle cycles, data line toggles when not acking
   always @(posedge clock_in) begin
      if (rom_rd_in && !rom_ack_out && cnt == wait_in) begin
         rom_ack_out <= 1'b1;
         rom_data_out <= rom_addr_in + 8'h11;
         cnt <= 3'h0;
      end else begin
         rom_ack_out <= 1'b0;
         rom_data_out <= ~rom_data_out;
         cnt <= (rom_rd_in && !rom_ack_out) ? cnt + 3'h1 : 3'h0;
      end
   end
endmodule

`default_nettype wire

// >>> bench/prc_cfg_regs_properties.sv
// assertions on the config block ports
`timescale 1ns/1ps
`default_nettype none

module prc_cfg_regs_properties (
   input wire logic               clock_in,
   input wire logic               reset_n_in,
   input wire logic               strap_agp_in,
   input wire logic               cfg_req_in,
   input wire logic               cfg_write_in,
   input wire prc_pkg::prc_byte_t cfg_addr_in,
   input wire prc_pkg::prc_word_t cfg_rdata_out,
   input wire logic               cfg_ack_out,
   input wire logic               alias_wr_in,
   input wire logic               mem_space_en_in,
   input wire logic               mem_req_in,
   input wire prc_pkg::prc_word_t mem_addr_in,
   input wire logic               rom_claim_out,
   input wire logic               rom_in_image_out,
   input wire logic [15:0]        rom_offset_out,
   input wire logic               rom_rd_out,
   input wire prc_pkg::prc_byte_t rom_addr_out,
   input wire logic               rom_ack_in,
   input wire logic               id_ready_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);

   // ------------------------------------------------------------------
   // config bus answers
   // ------------------------------------------------------------------
   a_ack_single_pulse: assert property (
      cfg_ack_out |=> !cfg_ack_out) else $error("ack too long");
   a_ack_has_cause: assert property (
      cfg_ack_out |-> $past(cfg_req_in && id_ready_out))
      else $error("ack without request");
   a_req_gets_ack: assert property (
      cfg_req_in && id_ready_out && !cfg_ack_out |=> cfg_ack_out)
      else $error("request not answered");
   a_write_reads_zero: assert property (
      cfg_ack_out && $past(cfg_write_in) |-> cfg_rdata_out == 32'h0)
      else $error("write answer data not zero");
   a_cap_offset_value: assert property (
      cfg_ack_out && $past(!cfg_write_in && cfg_addr_in[7:2] == 6'h0d)
      |-> cfg_rdata_out == (strap_agp_in ? 32'h0000_0044 : 32'h0))
      else $error("cap pointer value wrong");
   a_rsvd_word_zero: assert property (
      cfg_ack_out && $past(cfg_addr_in[7:2] == 6'h0e) |->
      cfg_rdata_out == 32'h0) else $error("reserved word not zero");
   a_rom_base_low: assert property (
      cfg_ack_out && $past(cfg_addr_in[7:2] == 6'h0c) |->
      cfg_rdata_out[21:1] == 21'h0) else $error("base low bits set");

   // ------------------------------------------------------------------
   // rom window decode and identity fetch
   // ------------------------------------------------------------------
   a_claim_has_cause: assert property (
      rom_claim_out |-> $past(mem_req_in && mem_space_en_in))
      else $error("claim without enable");
   a_image_offset: assert property (
      rom_claim_out && rom_in_image_out |->
      rom_offset_out == $past(mem_addr_in[15:0]))
      else $error("image offset wrong");
   a_fetch_addr_range: assert property (
      rom_rd_out |-> rom_addr_out inside {[8'h54:8'h57]})
      else $error("fetch address out of range");
   a_fetch_rd_hold: assert property (
      rom_rd_out && !rom_ack_in |=> rom_rd_out && $stable(rom_addr_out))
      else $error("fetch request dropped early");

   c_fetch_ack: cover property (rom_rd_out && rom_ack_in);
   c_claim: cover property (rom_claim_out && rom_in_image_out);
   c_alias: cover property (alias_wr_in);
endmodule

bind prc_cfg_regs prc_cfg_regs_properties prc_cfg_regs_properties_inst (
   .clock_in, .reset_n_in, .strap_agp_in, .cfg_req_in, .cfg_write_in,
   .cfg_addr_in, .cfg_rdata_out, .cfg_ack_out, .alias_wr_in,
   .mem_space_en_in, .mem_req_in, .mem_addr_in, .rom_claim_out,
   .rom_in_image_out, .rom_offset_out, .rom_rd_out, .rom_addr_out,
   .rom_ack_in, .id_ready_out);

`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the config words block
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import prc_pkg::*;
   logic        clock_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic        strap_rom_id_in = 1'b0, strap_agp_in = 1'b0;
   logic        cfg_req_in = 1'b0, cfg_write_in = 1'b0;
   prc_byte_t   cfg_addr_in = 8'h00;
   logic [3:0]  cfg_be_in = 4'h0, alias_be_in = 4'h0;
   prc_word_t   cfg_wdata_in = '0, alias_data_in = '0, mem_addr_in = '0;
   logic        alias_wr_in = 1'b0, mem_space_en_in = 1'b0;
   logic        mem_req_in = 1'b0, rom_ack_in;
   prc_byte_t   rom_data_in, rom_addr_out;
   prc_word_t   cfg_rdata_out, q;
   logic        cfg_ack_out, rom_claim_out, rom_in_image_out;
   logic        rom_rd_out, id_ready_out;
   logic [15:0] rom_offset_out;
   logic [2:0]  rom_wait = 3'h0;
   int          n_fail = 0, samples_checked = 0;

   // 20 MHz clock
   always #25 clock_in = ~clock_in;

   prc_cfg_regs prc_cfg_regs_inst (.clock_in, .reset_n_in,
      .strap_rom_id_in, .strap_agp_in, .cfg_req_in, .cfg_write_in,
      .cfg_addr_in, .cfg_be_in, .cfg_wdata_in, .cfg_rdata_out,
      .cfg_ack_out, .alias_wr_in, .alias_be_in, .alias_data_in,
      .mem_space_en_in, .mem_req_in, .mem_addr_in, .rom_claim_out,
      .rom_in_image_out, .rom_offset_out, .rom_rd_out, .rom_addr_out,
      .rom_ack_in, .rom_data_in, .id_ready_out);

   prc_rom_model prc_rom_model_inst (.clock_in, .wait_in(rom_wait),
      .rom_rd_in(rom_rd_out), .rom_addr_in(rom_addr_out),
      .rom_ack_out(rom_ack_in), .rom_data_out(rom_data_in));

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic results();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input prc_word_t got, input prc_word_t exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc();
      @(posedge clock_in);
      #1;
   endtask

   // reset with straps, then wait for the identity word
   task automatic rst(input logic rom, input logic agp, input logic [2:0] w);
      int i;
      reset_n_in = 1'b0;
      strap_rom_id_in = rom;
      strap_agp_in = agp;
      rom_wait = w;
      repeat (5) cyc();
      reset_n_in = 1'b1;
      for (i = 0; i < 200 && id_ready_out !== 1'b1; i++) cyc();
      if (i == 200) begin
         n_fail++;
         results();
      end
   endtask

   // one config access, held until acknowledged
   task automatic cfg(input logic w, input prc_byte_t a, input logic [3:0] be,
                      input prc_word_t d, output prc_word_t r);
      int i;
      cfg_req_in = 1'b1;
      cfg_write_in = w;
      cfg_addr_in = a;
      cfg_be_in = be;
      cfg_wdata_in = d;
      for (i = 0; i < 100 && cfg_ack_out !== 1'b1; i++) cyc();
      if (i == 100) begin
         n_fail++;
         results();
      end
      r = cfg_rdata_out;
      cfg_req_in = 1'b0;
      cyc();
   endtask

   task automatic rd(input prc_byte_t a, input prc_word_t exp);
      cfg(1'b0, a, 4'h0, 32'h0, q);
      chk(q, exp);
   endtask

   // one memory cycle against the rom window
   task automatic md(input logic ms, input prc_word_t a, input logic c,
                     input logic im, input logic [15:0] o);
      mem_space_en_in = ms;
      mem_req_in = 1'b1;
      mem_addr_in = a;
      cyc();
      mem_req_in = 1'b0;
      chk({30'h0, rom_claim_out, rom_in_image_out}, {30'h0, c, im});
      chk({16'h0, rom_offset_out}, {16'h0, o});
      // idle edge so the next cycle does not re-raise the strobe at once
      cyc();
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_rom_id();
      rst(1'b1, 1'b1, 3'h3);
      rd(8'h2c, 32'h6867_6665);
      cfg(1'b1, 8'h2c, 4'hf, 32'hffff_ffff, q);
      rd(8'h2c, 32'h6867_6665);
      rd(8'h34, 32'h0000_0044);
      cfg(1'b1, 8'h38, 4'hf, 32'hffff_ffff, q);
      rd(8'h38, 32'h0000_0000);
      rd(8'h3c, 32'h0000_0000);
   endtask

   task automatic t_rom_base();
      rd(8'h30, 32'h0000_0000);
      cfg(1'b1, 8'h30, 4'hf, 32'hffff_ffff, q);
      rd(8'h30, 32'hffc0_0001);
      cfg(1'b1, 8'h30, 4'h8, 32'h0000_0000, q);
      rd(8'h30, 32'h00c0_0001);
   endtask

   task automatic t_decode();
      md(1'b0, 32'h00c0_1234, 1'b0, 1'b0, 16'h0000);
      md(1'b1, 32'h00c0_1234, 1'b1, 1'b1, 16'h1234);
      md(1'b1, 32'h00c1_0000, 1'b1, 1'b0, 16'h0000);
      md(1'b1, 32'h0100_0000, 1'b0, 1'b0, 16'h0000);
      cfg(1'b1, 8'h30, 4'h1, 32'h0000_0000, q);
      md(1'b1, 32'h00c0_1234, 1'b0, 1'b0, 16'h0000);
   endtask

   task automatic t_alias();
      rst(1'b0, 1'b0, 3'h0);
      chk({31'h0, rom_rd_out}, 32'h0);
      alias_wr_in = 1'b1;
      alias_be_in = 4'hf;
      alias_data_in = 32'h1234_abcd;
      cyc();
      alias_be_in = 4'h1;
      alias_data_in = 32'h0000_00ff;
      cyc();
      alias_wr_in = 1'b0;
      cyc();
      rd(8'h2c, 32'h1234_abff);
      rd(8'h34, 32'h0000_0000);
   endtask

   initial begin
      t_rom_id();
      t_rom_base();
      t_decode();
      t_alias();
      rst(1'b1, 1'b0, 3'h0);
      rd(8'h2c, 32'h6867_6665);
      results();
   end
endmodule

`default_nettype wire
